/* File: common/tcc_defines.svh */
/*
  register offsets, field positions and reset values of the
  three channel capture/compare timer. assumes word addresses on the
  peripheral bus, bit 0 of the address ignored.
*/
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define TCC_VECTOR_OFS   16'h012e
`define TCC_CONTROL_OFS  16'h0160
`define TCC_CH0_CTL_OFS  16'h0162
`define TCC_CH1_CTL_OFS  16'h0164
`define TCC_CH2_CTL_OFS  16'h0166
`define TCC_COUNT_OFS    16'h0170
`define TCC_CH0_VAL_OFS  16'h0172
`define TCC_CH1_VAL_OFS  16'h0174
`define TCC_CH2_VAL_OFS  16'h0176
// ****************************************************************
// timer control fields
// ****************************************************************
`define TCC_CTL_SRC_LSB  8
`define TCC_CTL_DIV_LSB  6
`define TCC_CTL_MODE_LSB 4
`define TCC_CTL_CLR_BIT  2
`define TCC_CTL_IE_BIT   1
`define TCC_CTL_FLG_BIT  0
// ****************************************************************
// channel control fields
// ****************************************************************
`define TCC_CC_EDGE_LSB  14
`define TCC_CC_INSEL_LSB 12
`define TCC_CC_CAP_BIT   8
`define TCC_CC_OMOD_LSB  5
`define TCC_CC_IE_BIT    4
`define TCC_CC_OUT_BIT   2
`define TCC_CC_FLG_BIT   0
// ****************************************************************
// vector word values and reset value
// ****************************************************************
`define TCC_IV_NONE      16'h0000
`define TCC_IV_CH1       16'h0002
`define TCC_IV_CH2       16'h0004
`define TCC_IV_OVF       16'h000a
`define TCC_RESET_WORD   16'h0000
`endif

/* File: common/tcc_pkg.sv */
/*
  types of the capture/compare timer. assumes nothing else.
*/
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_STOP = 2'b00,
    TCC_UP   = 2'b01,
    TCC_CONT = 2'b10,
    TCC_UPDN = 2'b11
  } tcc_mode_e;
  typedef enum logic [1:0] {
    TCC_SRC_EXTA = 2'b00,
    TCC_SRC_AUX  = 2'b01,
    TCC_SRC_SUB  = 2'b10,
    TCC_SRC_EXTB = 2'b11
  } tcc_src_e;
  typedef logic [15:0] tcc_word_t;
endpackage : tcc_pkg

/* File: rtl/tcc_timer.sv */
/*
  three channel capture/compare timer with 16-bit word registers.
  assumes all pin inputs and clock sources are synchronous to SYS_CLK;
  timer clock sources are sampled and their rising edges advance the
  prescaler. one bus access per cycle; reads return the same cycle.
*/
// Overview of operation
// - one counter, three capture/compare channels
// - source select: pin a, aux, sub, pin b
// - prescaler divides by one two four eight
// - counter halts, word read and write
// - stop, continuous, up, up/down modes
// - each channel capture or compare mode
// - capture on rising, falling or both
// - capture enable bit changeable anytime
// - each channel has its own capture pin
// - channel 2 alternate input is aux clock
// - input select 2 or 3 is software
// - per-channel output unit, pwm capable
// - channel 0 interrupt plus shared interrupt
// - vector word identifies highest pending shared source
// - interrupt flags live inside the timer
// - shared vector 0fff0, channel 0 0fff2
`timescale 1ns/10ps
`include "tcc_defines.svh"
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int CH_N = 3
) (
  // clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             SYS_RST,
  // peripheral word bus
  input  wire logic [15:0]      BUS_ADDR,
  input  wire logic             BUS_WR,
  input  wire logic             BUS_RD,
  input  wire logic [15:0]      BUS_WDATA,
  output logic      [15:0]      BUS_RDATA,
  // timer clock sources
  input  wire logic             EXTERNAL_TIMER_CLOCK_A,
  input  wire logic             EXTERNAL_TIMER_CLOCK_B,
  input  wire logic             AUXILIARY_CLOCK,
  input  wire logic             SUBSYSTEM_CLOCK,
  // capture pins and compare outputs
  input  wire logic [CH_N-1:0]  CAPTURE_PIN,
  output logic      [CH_N-1:0]  COMPARE_OUT,
  // interrupt requests
  output logic                  IRQ_CHANNEL0,
  output logic                  IRQ_SHARED
);
  // ****************************************************************
  // registers
  // ****************************************************************
  tcc_word_t            ctl_reg, ctl_next;
  tcc_word_t            cnt_reg, cnt_next;
  tcc_word_t            cc_ctl_reg [CH_N];
  tcc_word_t            cc_ctl_next[CH_N];
  tcc_word_t            cc_val_reg [CH_N];
  tcc_word_t            cc_val_next[CH_N];
  logic      [CH_N-1:0] in_prev_reg;
  logic      [CH_N-1:0] out_reg, out_next;
  logic                 src_prev_reg;
  logic      [2:0]      pre_reg, pre_next;
  logic                 down_reg, down_next;

  // word decode ignores the byte address bit
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a[15:1] == o[15:1]);
  endfunction : hit

  // ****************************************************************
  // clock source and prescaler
  // ****************************************************************
  tcc_src_e  src_sel;
  tcc_mode_e mode;
  logic      src_lvl, src_rise, tick, div_hit, clr_cmd;
  logic [2:0] div_mask;
  assign src_sel = tcc_src_e'(ctl_reg[`TCC_CTL_SRC_LSB +: 2]);
  assign mode    = tcc_mode_e'(ctl_reg[`TCC_CTL_MODE_LSB +: 2]);
  assign src_lvl = (src_sel == TCC_SRC_EXTA) ? EXTERNAL_TIMER_CLOCK_A :
                   (src_sel == TCC_SRC_AUX)  ? AUXILIARY_CLOCK :
                   (src_sel == TCC_SRC_SUB)  ? SUBSYSTEM_CLOCK :
                                               EXTERNAL_TIMER_CLOCK_B;
  assign src_rise = src_lvl & ~src_prev_reg;
  // mask is 0,1,3,7 for ratio 1,2,4,8
  assign div_mask = 3'((4'h1 << ctl_reg[`TCC_CTL_DIV_LSB +: 2]) - 4'h1);
  assign div_hit  = ((pre_reg & div_mask) == div_mask);
  assign tick     = src_rise & div_hit & (mode != TCC_STOP);
  // the prescaler keeps counting source edges while stopped, so the
  // first tick after a start is only exact after a clear
  assign pre_next = clr_cmd ? 3'h0 : (src_rise ? pre_reg + 3'h1 : pre_reg);

  // ****************************************************************
  // counter
  // ****************************************************************
  tcc_word_t period;
  logic      at_top, wrap;
  assign period = cc_val_reg[0];
  assign at_top = (cnt_reg >= period);
  // counter returning to zero marks overflow
  assign wrap   = tick & (cnt_next == 16'h0000) & (cnt_reg != 16'h0000);
  assign clr_cmd = BUS_WR & hit(BUS_ADDR, `TCC_CONTROL_OFS) &
                   BUS_WDATA[`TCC_CTL_CLR_BIT];
  always_comb begin
    cnt_next  = cnt_reg;
    down_next = down_reg;
    if (BUS_WR && hit(BUS_ADDR, `TCC_COUNT_OFS)) begin
      cnt_next = BUS_WDATA;
    end else if (clr_cmd) begin
      cnt_next  = 16'h0000;
      down_next = 1'b0;
    end else if (tick) begin
      unique case (mode)
        TCC_CONT: cnt_next = cnt_reg + 16'h0001;
        // channel 0 value sets the period
        TCC_UP:   cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
        // up to period, then down to zero
        TCC_UPDN: begin
          if (!down_reg && at_top) begin
            down_next = (period != 16'h0000);
            cnt_next  = (period != 16'h0000) ? period - 16'h0001 : 16'h0000;
          end else if (down_reg) begin
            cnt_next  = cnt_reg - 16'h0001;
            down_next = (cnt_reg != 16'h0001);
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
        TCC_STOP: cnt_next = cnt_reg;
      endcase
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  logic [CH_N-1:0] ch_in, cap_evt, cmp_evt, ev;
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      logic [1:0] sel;
      logic [1:0] edg;
      logic       rise, fall;
      sel = cc_ctl_reg[i][`TCC_CC_INSEL_LSB +: 2];
      edg = cc_ctl_reg[i][`TCC_CC_EDGE_LSB +: 2];
      // input routing, software level for 2 and 3
      unique case (sel)
        2'h0: ch_in[i] = CAPTURE_PIN[i];
        2'h1: ch_in[i] = (i == 2) ? AUXILIARY_CLOCK : 1'b0;
        2'h2: ch_in[i] = 1'b0;
        2'h3: ch_in[i] = 1'b1;
      endcase
      rise = ch_in[i] & ~in_prev_reg[i];
      fall = ~ch_in[i] & in_prev_reg[i];
      // edge select gated by capture mode bit
      cap_evt[i] = cc_ctl_reg[i][`TCC_CC_CAP_BIT] &
                   ((edg[0] & rise) | (edg[1] & fall));
      // compare match on a timer tick
      cmp_evt[i] = ~cc_ctl_reg[i][`TCC_CC_CAP_BIT] & tick &
                   (cnt_next == cc_val_reg[i]);
      ev[i] = cap_evt[i] | cmp_evt[i];
    end
  end

  // output unit: 0 follows out bit, 1 set, 2 toggle/reset pwm
  // 3 set/reset pwm (set on match, reset at period), 4 toggle, others reset
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      logic [2:0] om;
      om = cc_ctl_reg[i][`TCC_CC_OMOD_LSB +: 3];
      out_next[i] = out_reg[i];
      unique case (om)
        3'h0: out_next[i] = cc_ctl_reg[i][`TCC_CC_OUT_BIT];
        3'h1: if (cmp_evt[i]) out_next[i] = 1'b1;
        3'h2: begin
          if (cmp_evt[i]) out_next[i] = ~out_reg[i];
          else if (cmp_evt[0]) out_next[i] = 1'b0;
        end
        3'h3: begin
          if (cmp_evt[i]) out_next[i] = 1'b1;
          else if (cmp_evt[0]) out_next[i] = 1'b0;
        end
        3'h4: if (cmp_evt[i]) out_next[i] = ~out_reg[i];
        default: if (cmp_evt[i]) out_next[i] = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // interrupt vector and flags
  // ****************************************************************
  logic [CH_N-1:0] flg, ie;
  logic            ovf_pend, vec_rd;
  tcc_word_t       vec_word;
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      flg[i] = cc_ctl_reg[i][`TCC_CC_FLG_BIT];
      ie[i]  = cc_ctl_reg[i][`TCC_CC_IE_BIT];
    end
  end
  assign ovf_pend = ctl_reg[`TCC_CTL_FLG_BIT] & ctl_reg[`TCC_CTL_IE_BIT];
  // highest pending source first: channel 1, channel 2, overflow
  assign vec_word = (flg[1] & ie[1]) ? `TCC_IV_CH1 :
                    (flg[2] & ie[2]) ? `TCC_IV_CH2 :
                    ovf_pend         ? `TCC_IV_OVF : `TCC_IV_NONE;
  assign vec_rd   = BUS_RD & hit(BUS_ADDR, `TCC_VECTOR_OFS);
  // two requests, vector address fixed by the system
  assign IRQ_CHANNEL0 = flg[0] & ie[0];
  assign IRQ_SHARED   = (vec_word != `TCC_IV_NONE);
  assign COMPARE_OUT  = out_reg;

  // flags held in the control words; event set beats clear
  always_comb begin
    ctl_next = ctl_reg;
    if (BUS_WR && hit(BUS_ADDR, `TCC_CONTROL_OFS)) begin
      ctl_next = BUS_WDATA;
      ctl_next[`TCC_CTL_CLR_BIT] = 1'b0;
    end
    // reading the vector acknowledges the source it names
    if (vec_rd && vec_word == `TCC_IV_OVF) begin
      ctl_next[`TCC_CTL_FLG_BIT] = 1'b0;
    end
    if (wrap) begin
      ctl_next[`TCC_CTL_FLG_BIT] = 1'b1;
    end
    for (int i = 0; i < CH_N; i++) begin
      cc_ctl_next[i] = cc_ctl_reg[i];
      cc_val_next[i] = cc_val_reg[i];
      if (BUS_WR && hit(BUS_ADDR, 16'(`TCC_CH0_CTL_OFS + 2 * i))) begin
        cc_ctl_next[i] = BUS_WDATA;
      end
      if (BUS_WR && hit(BUS_ADDR, 16'(`TCC_CH0_VAL_OFS + 2 * i))) begin
        cc_val_next[i] = BUS_WDATA;
      end
      if (vec_rd && ((i == 1 && vec_word == `TCC_IV_CH1) ||
                     (i == 2 && vec_word == `TCC_IV_CH2))) begin
        cc_ctl_next[i][`TCC_CC_FLG_BIT] = 1'b0;
      end
      if (cap_evt[i]) begin
        cc_val_next[i] = cnt_reg;
      end
      if (ev[i]) begin
        cc_ctl_next[i][`TCC_CC_FLG_BIT] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    BUS_RDATA = 16'h0000;
    if (BUS_RD) begin
      if (hit(BUS_ADDR, `TCC_VECTOR_OFS))  BUS_RDATA = vec_word;
      if (hit(BUS_ADDR, `TCC_CONTROL_OFS)) BUS_RDATA = ctl_reg;
      if (hit(BUS_ADDR, `TCC_COUNT_OFS))   BUS_RDATA = cnt_reg;
      for (int i = 0; i < CH_N; i++) begin
        if (hit(BUS_ADDR, 16'(`TCC_CH0_CTL_OFS + 2 * i))) begin
          BUS_RDATA = cc_ctl_reg[i] | {12'h000, ch_in[i], 3'h0};
        end
        if (hit(BUS_ADDR, 16'(`TCC_CH0_VAL_OFS + 2 * i))) begin
          BUS_RDATA = cc_val_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // state update
  // ****************************************************************
  // all state in one clocked process
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctl_reg      <= `TCC_RESET_WORD;
      cnt_reg      <= `TCC_RESET_WORD;
      pre_reg      <= 3'h0;
      down_reg     <= 1'b0;
      src_prev_reg <= 1'b0;
      in_prev_reg  <= '0;
      out_reg      <= '0;
      for (int i = 0; i < CH_N; i++) begin
        cc_ctl_reg[i] <= `TCC_RESET_WORD;
        cc_val_reg[i] <= `TCC_RESET_WORD;
      end
    end else begin
      ctl_reg      <= ctl_next;
      cnt_reg      <= cnt_next;
      pre_reg      <= pre_next;
      down_reg     <= down_next;
      src_prev_reg <= src_lvl;
      in_prev_reg  <= ch_in;
      out_reg      <= out_next;
      cc_ctl_reg   <= cc_ctl_next;
      cc_val_reg   <= cc_val_next;
    end
  end
endmodule : tcc_timer

/* File: verification/tcc_timer_monitor.sv */
/* port checker of the capture/compare timer, bound to tcc_timer.
   assumes even word addresses on the bus. */
`timescale 1ns/10ps
module tcc_timer_monitor #(
  parameter int CH_N = 3
) (
  // clock, reset and bus
  input wire logic            SYS_CLK,
  input wire logic            SYS_RST,
  input wire logic [15:0]     BUS_ADDR,
  input wire logic            BUS_WR,
  input wire logic            BUS_RD,
  input wire logic [15:0]     BUS_WDATA,
  input wire logic [15:0]     BUS_RDATA,
  // outputs and requests
  input wire logic [CH_N-1:0] COMPARE_OUT,
  input wire logic            IRQ_CHANNEL0,
  input wire logic            IRQ_SHARED
);
  // decode; bit 0 dropped since the bus ignores it
  wire logic [15:0] wa     = {BUS_ADDR[15:1], 1'b0};
  wire logic        rd_vec = BUS_RD && wa == 16'h012e;
  wire logic        rd_ctl = BUS_RD && wa == 16'h0160;
  wire logic        wr_ctl = BUS_WR && wa == 16'h0160;
  wire logic        rd_c0  = BUS_RD && wa == 16'h0162;
  wire logic        rd_c1  = BUS_RD && wa == 16'h0164;
  wire logic        in_map = wa == 16'h012e
    || (wa >= 16'h0160 && wa <= 16'h0166)
    || (wa >= 16'h0170 && wa <= 16'h0176);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // ****************
  // assertions
  // ****************
  reset_quiet_a: assert property ($fell(SYS_RST) |->
    !IRQ_CHANNEL0 && !IRQ_SHARED && COMPARE_OUT == '0)
    else $error("output active after reset");
  idle_read_a: assert property (!BUS_RD |-> BUS_RDATA == '0)
    else $error("read data not zero while idle");
  unmapped_read_a: assert property (BUS_RD && !in_map
    |-> BUS_RDATA == '0) else $error("hole read not zero");
  ctl_write_a: assert property (wr_ctl ##1 rd_ctl |->
    (BUS_RDATA & 16'h03f2) == ($past(BUS_WDATA) & 16'h03f2))
    else $error("control write not kept");
  vector_code_a: assert property (rd_vec |->
    BUS_RDATA inside {16'h0000, 16'h0002, 16'h0004, 16'h000a})
    else $error("vector word out of range");
  shared_req_a: assert property (rd_vec |->
    IRQ_SHARED == (BUS_RDATA != '0)) else $error("shared request wrong");
  ch0_req_a: assert property (rd_c0 |->
    IRQ_CHANNEL0 == (BUS_RDATA[4] && BUS_RDATA[0]))
    else $error("channel 0 request wrong");
  out_level_a: assert property (rd_c1 && BUS_RDATA[7:5] == 3'h0
    ##1 rd_c1 && $stable(BUS_RDATA) |-> COMPARE_OUT[1] == BUS_RDATA[2])
    else $error("output unit level wrong");
endmodule : tcc_timer_monitor
bind tcc_timer tcc_timer_monitor #(.CH_N(CH_N)) u_tcc_timer_monitor (
  .SYS_CLK, .SYS_RST, .BUS_ADDR, .BUS_WR, .BUS_RD, .BUS_WDATA,
  .BUS_RDATA, .COMPARE_OUT, .IRQ_CHANNEL0, .IRQ_SHARED);

/* File: verification/tcc_pin_model.sv */
/* pin side of the timer: four clock sources and the capture pins.
   assumes the bench sets run and the pin levels. */
`timescale 1ns/10ps
module tcc_pin_model (
  // clock and bench control
  input  wire logic       sys_clk,
  input  wire logic       run,
  input  wire logic [2:0] pin_lvl,
  // timer pins
  output logic            ext_a,
  output logic            aux,
  output logic            sub,
  output logic            ext_b,
  output logic [2:0]      cap
);
  logic [1:0] div_reg [4];
  logic [3:0] clk_reg;
  // source s toggles every s+1 cycles, so rates differ
  always_ff @(posedge sys_clk) begin
    for (int s = 0; s < 4; s++) begin
      if (!run || div_reg[s] == 2'(s)) begin
        div_reg[s] <= 2'h0;
        clk_reg[s] <= run && !clk_reg[s];
      end else begin
        div_reg[s] <= div_reg[s] + 2'h1;
      end
    end
  end
  assign ext_a = clk_reg[0];
  assign aux   = clk_reg[1];
  assign sub   = clk_reg[2];
  assign ext_b = clk_reg[3];
  // each capture pin follows the bench
  assign cap   = pin_lvl;
endmodule : tcc_pin_model

/* File: verification/test_tcc_timer.sv */
/* self-checking bench of the capture/compare timer.
   assumes tcc_pin_model and the bound port checker. */
`timescale 1ns/10ps
module test_tcc_timer import tcc_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        sys_rst, bus_wr, bus_rd, run, irq0, irqs;
  logic        ext_a, ext_b, aux, sub;
  logic [15:0] bus_addr, bus_wdata;
  tcc_word_t   bus_rdata, w1, w2, v, base;
  logic [2:0]  pin_lvl, cap_pin, cmp_out;
  int          seed = 46, n_mismatch = 0, cmp_count = 0, cycles = 0, p;
  tcc_word_t   exp_q[$], msk_q[$], ex_w;
  string       nm_q[$], nm_w;
  always #25 sys_clk = ~sys_clk;
  tcc_timer #(.CH_N(3)) u_tcc_timer (.SYS_CLK(sys_clk),
    .SYS_RST(sys_rst), .BUS_ADDR(bus_addr), .BUS_WR(bus_wr),
    .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
    .EXTERNAL_TIMER_CLOCK_A(ext_a), .EXTERNAL_TIMER_CLOCK_B(ext_b),
    .AUXILIARY_CLOCK(aux), .SUBSYSTEM_CLOCK(sub),
    .CAPTURE_PIN(cap_pin), .COMPARE_OUT(cmp_out),
    .IRQ_CHANNEL0(irq0), .IRQ_SHARED(irqs));
  tcc_pin_model u_tcc_pin_model (.sys_clk(sys_clk), .run(run),
    .pin_lvl(pin_lvl), .ext_a(ext_a), .aux(aux), .sub(sub),
    .ext_b(ext_b), .cap(cap_pin));
  // ****************
  // bus tasks
  // ****************
  // strobes stay up between transfers, so idle is the only release
  task automatic idle(input int n);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  task automatic wr(input tcc_word_t a, input tcc_word_t d);
    bus_rd = 1'b0;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask : wr
  // the expectation is queued here and retired by the watcher
  task automatic rd(input string nm, input tcc_word_t a, input tcc_word_t e,
                    input tcc_word_t m = 16'hffff);
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    bus_addr = a;
    nm_q.push_back(nm);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge sys_clk);
    #1;
  endtask : rd
  // one capture input edge, from the pin or from software
  task automatic edge_in(input int ch, input int sw, input logic lvl);
    if (sw) wr(16'(16'h0162 + 2 * ch), base | (lvl ? 16'h1000 : 16'h0));
    else pin_lvl[ch] = lvl;
    idle(4);
  endtask : edge_in
  task automatic chk_word(input string nm, input tcc_word_t e, s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // watcher: each read cycle retires the oldest note
  always @(posedge sys_clk) begin
    if (bus_rd === 1'b1) begin
      nm_w = nm_q.pop_front();
      ex_w = exp_q.pop_front();
      chk_word(nm_w, ex_w, bus_rdata & msk_q.pop_front());
      // shared request stands while the vector word is nonzero
      if (bus_addr == 16'h012e)
        chk_word("shared request", 16'(ex_w != 16'h0), 16'(irqs));
    end
  end
  // hang guard, well above the fewer than 1500 cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    sys_rst = 1'b1;
    {bus_wr, bus_rd, run, bus_addr, bus_wdata, pin_lvl} = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    idle(1);
    rd("vector", 16'h012e, 16'h0000);
    for (int a = 'h160; a < 'h178; a += 2) rd("reset", 16'(a), 16'h0);
    wr(16'h0168, 16'hffff);
    wr(16'h012e, 16'hffff);
    rd("hole", 16'h0168, 16'h0000);
    rd("vector", 16'h012e, 16'h0000);
    w1 = 16'($random(seed));
    wr(16'h0170, w1);
    rd("count", 16'h0170, w1);
    run = 1'b1;
    idle(9);
    rd("halted", 16'h0170, w1);
    wr(16'h0160, 16'h0302);
    rd("control", 16'h0160, 16'h0302, 16'h03f2);
    for (int b = 0; b < 2; b++) begin
      base = b ? 16'h0000 : 16'h0004;
      wr(16'h0164, base);
      rd("out", 16'h0164, base, 16'h00e4);
      rd("out", 16'h0164, base, 16'h00e4);
    end
    // every source with its own ratio, continuous counting
    for (int s = 0; s < 4; s++) begin
      v = 16'h0004 + 16'($random(seed) & 3);
      p = 2 * (s + 1) << s;
      wr(16'h0160, 16'h0004);
      wr(16'h0170, 16'h0000);
      wr(16'h0164, 16'h0010);
      wr(16'h0174, v);
      wr(16'h0160, 16'(s << 8 | s << 6) | 16'h0020);
      idle(p * (v - 1) - 4);
      rd("early", 16'h0164, 16'h0000, 16'h0001);
      idle(2 * p + 6);
      rd("match", 16'h0164, 16'h0001, 16'h0001);
      rd("vector", 16'h012e, 16'h0002);
      rd("vector", 16'h012e, 16'h0000);
    end
    // up and up/down return to zero within the channel 0 period
    for (int m = 1; m < 4; m += 2) begin
      wr(16'h0160, 16'h0004);
      wr(16'h0170, 16'h0000);
      wr(16'h0164, 16'h0000);
      wr(16'h0162, 16'h0010);
      wr(16'h0172, 16'h0003);
      wr(16'h0160, 16'(16'h0202 | m << 4));
      idle(60);
      rd("overflow", 16'h012e, 16'h000a);
      rd("period", 16'h0162, 16'h0001, 16'h0001);
    end
    wr(16'h0160, 16'h0004);
    for (int ch = 0; ch < 3; ch++)
      for (int e = 0; e < 4; e++)
        for (int sw = 0; sw < 2; sw++) begin
          base = 16'(e << 14 | sw << 13) | 16'h0100;
          w1 = 16'($random(seed));
          w2 = 16'($random(seed));
          wr(16'(16'h0172 + 2 * ch), 16'h0000);
          wr(16'h0170, w1);
          wr(16'(16'h0162 + 2 * ch), base);
          edge_in(ch, sw, 1'b1);
          rd("rise", 16'(16'h0172 + 2 * ch), e[0] ? w1 : 16'h0);
          wr(16'h0170, w2);
          edge_in(ch, sw, 1'b0);
          rd("fall", 16'(16'h0172 + 2 * ch),
             e[1] ? w2 : e[0] ? w1 : 16'h0);
          rd("flag", 16'(16'h0162 + 2 * ch),
             16'(sw ? e[1] : e != 0), 16'h0001);
        end
    w1 = 16'($random(seed));
    wr(16'h0170, w1);
    wr(16'h0176, 16'h0000);
    wr(16'h0166, 16'h5100);
    idle(12);
    rd("alternate", 16'h0176, w1);
    complete_run();
  end
endmodule : test_tcc_timer
